// *** logic/bert_pkg.sv ***
// Constants, register map and state types of the bit error checker receive block.
// Assumes one bit clock: one received bit per rising edge of aclk.
package bert_pkg;
    // Register byte offsets
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_TRIG = 12'h004;
    localparam logic [11:0] OFF_THR = 12'h008;
    localparam logic [11:0] OFF_SYNC_NOW = 12'h00c;
    localparam logic [11:0] OFF_STATUS = 12'h010;
    localparam logic [11:0] OFF_ERRS = 12'h014;
    localparam logic [11:0] OFF_DET_LO = 12'h018;
    localparam logic [11:0] OFF_DET_HI = 12'h01c;
    localparam logic [11:0] OFF_DET_END = 12'h020;
    localparam logic [11:0] OFF_PLEN = 12'h024;
    localparam logic [11:0] OFF_FW = 12'h040;
    localparam logic [11:0] OFF_MEM = 12'h100;
    // Counts and sizes; window and trigger lengths in bit times (one clock each)
    localparam int WIN_BITS = 4000;
    localparam int SYNC_BER_DEN = 1000;
    localparam logic [11:0] THR_RST = 12'(WIN_BITS / SYNC_BER_DEN);
    localparam logic [11:0] TRIG_WIN_BITS = 12'h800;
    localparam logic [11:0] TRIG_PULSE_BITS = 12'h028;
    localparam int PRBS_W = 15;
    localparam logic [14:0] PRBS_LAST = 15'h7ffe;
    localparam int MEM_WORDS = 16;
    localparam logic [9:0] PLEN_RST = 10'h200;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [39:0] SKP_TAIL = 40'haaaaaaaae1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {S_HUNT = 2'b00, S_MEAS = 2'b01, S_SYNC = 2'b10} sync_st_t;
    typedef enum logic [1:0] {T_DIV = 2'b00, T_PAT = 2'b01, T_FILL = 2'b10, T_SKP = 2'b11} trig_mode_t;
    typedef enum logic [1:0] {RM_BIT = 2'b00, RM_8B10B = 2'b01, RM_NOSKP = 2'b10, RM_RSVD = 2'b11} ratio_t;

    typedef struct packed {
        logic c130;
        logic c8b;
        ratio_t ratio;
        logic clk_rec;
        logic aux_data;
        logic manual;
        logic pat_mem;
    } ctrl_t;

    typedef struct packed {
        // Configuration
        ctrl_t ctrl;
        trig_mode_t tmode;
        logic [2:0] dsel;
        logic [11:0] thr;
        logic [47:0] det;
        logic [8:0] det_end;
        logic [9:0] plen;
        logic [3:0][39:0] fw_val;
        logic [3:0][39:0] fw_care;
        logic [3:0][1:0] fw_len;
        // Receive and sync
        logic rx_m;
        logic rx_s;
        logic [47:0] hist;
        sync_st_t st;
        logic [14:0] lfsr;
        logic [3:0] seedc;
        logic [8:0] ptr;
        logic [14:0] pcnt;
        logic [11:0] wbits;
        logic [11:0] werr;
        logic [11:0] lasterr;
        logic sync_ok;
        logic sync_loss;
        // Trigger and aux
        logic [6:0] dcnt;
        logic [11:0] tcnt;
        logic trig;
        logic aux;
        // Bus slave
        logic awready;
        logic wready;
        logic arready;
        logic aw_h;
        logic w_h;
        logic [11:0] awa;
        logic [31:0] wd;
        logic [3:0] ws;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_t;
endpackage : bert_pkg

// *** logic/bert_rx.sv ***
// Receive side of the bit error checker: pattern sync, error ratio, trigger and aux outputs.
// Assumes aclk is the bit clock in use and rx_data is the sliced data from the pin.
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module bert_rx
    import bert_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic rx_data,
    output logic trig_out,
    output logic aux_out,
    output logic clk_sel_rec,
    output logic sync_ok,
    output logic sync_loss,
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    state_t s;
    state_t n;
    logic [31:0] mem [MEM_WORDS];
    logic mem_we;
    logic [3:0] mem_wa;
    logic [31:0] mem_wd;
    logic [32:0] wr_old;
    logic [31:0] wv;
    logic [32:0] rd_res;
    logic syn_now;
    logic exp_bit;
    logic err_bit;
    logic [11:0] werr_sum;
    logic pat_ev;
    logic fill_hit;
    logic [7:0] div_len;
    logic trig_ev;

    // Divider length from the select field
    function automatic logic [7:0] div_n(input logic [2:0] sel);
        case (sel)
            3'h0: div_n = 8'h04;
            3'h1: div_n = 8'h08;
            3'h2: div_n = 8'h10;
            3'h3: div_n = 8'h14;
            3'h4: div_n = 8'h20;
            3'h5: div_n = 8'h40;
            default: div_n = 8'h80;
        endcase
    endfunction : div_n

    // Filler and skip trigger modes need matching coding and ratio setup
    function automatic logic mode_ok(input trig_mode_t m, input ctrl_t c);
        case (m)
            T_FILL: mode_ok = c.c8b && (c.ratio == RM_8B10B);
            T_SKP: mode_ok = c.c130 && (c.ratio == RM_NOSKP);
            default: mode_ok = 1'b1;
        endcase
    endfunction : mode_ok

    // Next pattern bit index, wrapping at the programmed length
    function automatic logic [8:0] next_ptr(input logic [8:0] p, input logic [9:0] len);
        next_ptr = ({1'b0, p} >= len - 10'h001) ? 9'h000 : p + 9'h001;
    endfunction : next_ptr

    // Register read mux; bit 32 flags an unmapped address
    function automatic logic [32:0] reg_read(input logic [11:0] a);
        logic [1:0] i;
        reg_read = '0;
        i = a[5:4];
        if (a[11:6] == OFF_FW[11:6]) begin
            case (a[3:2])
                2'h0: reg_read[31:0] = s.fw_val[i][31:0];
                2'h1: reg_read[31:0] = {22'h0, s.fw_len[i], s.fw_val[i][39:32]};
                2'h2: reg_read[31:0] = s.fw_care[i][31:0];
                default: reg_read[31:0] = {24'h0, s.fw_care[i][39:32]};
            endcase
        end else if (a[11:6] == OFF_MEM[11:6]) begin
            reg_read[31:0] = mem[a[5:2]];
        end else begin
            case ({a[11:2], 2'b00})
                OFF_CTRL: reg_read[31:0] = {24'h0, s.ctrl};
                OFF_TRIG: reg_read[31:0] = {27'h0, s.dsel, s.tmode};
                OFF_THR: reg_read[31:0] = {20'h0, s.thr};
                OFF_SYNC_NOW: reg_read[31:0] = 32'h0;
                OFF_STATUS: reg_read[31:0] = {28'h0, s.sync_loss, s.sync_ok, s.st};
                OFF_ERRS: reg_read[31:0] = {20'h0, s.lasterr};
                OFF_DET_LO: reg_read[31:0] = s.det[31:0];
                OFF_DET_HI: reg_read[31:0] = {16'h0, s.det[47:32]};
                OFF_DET_END: reg_read[31:0] = {23'h0, s.det_end};
                OFF_PLEN: reg_read[31:0] = {22'h0, s.plen};
                default: reg_read[32] = 1'b1;
            endcase
        end
    endfunction : reg_read

    // Register read values; byte lanes merged into the current register value
    always_comb begin
        wr_old = reg_read(s.awa);
        rd_res = reg_read(araddr);
        for (int b = 0; b < 4; b++) begin
            wv[8*b +: 8] = s.ws[b] ? s.wd[8*b +: 8] : wr_old[8*b +: 8];
        end
    end

    // Expected bit, error and match detectors
    assign exp_bit = s.ctrl.pat_mem ? mem[s.ptr[8:5]][s.ptr[4:0]] : (s.lfsr[14] ^ s.lfsr[13]);
    assign err_bit = s.rx_s ^ exp_bit;
    assign werr_sum = s.werr + {11'h0, err_bit};
    assign div_len = div_n(s.dsel);
    assign pat_ev = (s.st != S_HUNT) && (s.ctrl.pat_mem ? ({1'b0, s.ptr} == s.plen - 10'h001)
                                                        : (s.pcnt == PRBS_LAST));
    always_comb begin
        fill_hit = 1'b0;
        for (int i = 0; i < 4; i++) begin
            logic [39:0] lm;
            lm = (s.fw_len[i] == 2'h0) ? 40'h00000003ff : (s.fw_len[i] == 2'h1) ? 40'h00000fffff : '1;
            if (s.fw_len[i] != 2'h3 && (((s.hist[39:0] ^ s.fw_val[i]) & s.fw_care[i] & lm) == '0)) begin
                fill_hit = 1'b1;
            end
        end
    end
    always_comb begin
        case (s.tmode)
            T_PAT: trig_ev = pat_ev;
            T_FILL: trig_ev = fill_hit && mode_ok(T_FILL, s.ctrl);
            T_SKP: trig_ev = (s.hist[39:0] == SKP_TAIL) && mode_ok(T_SKP, s.ctrl);
            default: trig_ev = 1'b0;
        endcase
    end

    // Next-state logic
    always_comb begin
        n = s;
        mem_we = 1'b0;
        mem_wa = s.awa[5:2];
        mem_wd = wv;
        syn_now = 1'b0;
        n.rx_m = rx_data;
        n.rx_s = s.rx_m;
        n.hist = {s.hist[46:0], s.rx_s};
        // Write channel: address and data in either order
        if (awvalid && s.awready) begin
            n.aw_h = 1'b1;
            n.awa = awaddr;
        end
        if (wvalid && s.wready) begin
            n.w_h = 1'b1;
            n.wd = wdata;
            n.ws = wstrb;
        end
        if (s.bvalid && bready) begin
            n.bvalid = 1'b0;
        end
        if (s.aw_h && s.w_h && !s.bvalid) begin
            n.aw_h = 1'b0;
            n.w_h = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = wr_old[32] ? RESP_SLVERR : RESP_OKAY;
            if (s.awa[11:6] == OFF_FW[11:6]) begin
                case (s.awa[3:2])
                    2'h0: n.fw_val[s.awa[5:4]][31:0] = wv;
                    2'h1: begin
                        n.fw_val[s.awa[5:4]][39:32] = wv[7:0];
                        n.fw_len[s.awa[5:4]] = wv[9:8];
                    end
                    2'h2: n.fw_care[s.awa[5:4]][31:0] = wv;
                    default: n.fw_care[s.awa[5:4]][39:32] = wv[7:0];
                endcase
            end else if (s.awa[11:6] == OFF_MEM[11:6]) begin
                mem_we = 1'b1;
            end else begin
                case ({s.awa[11:2], 2'b00})
                    OFF_CTRL: n.ctrl = ctrl_t'(wv[7:0]);
                    OFF_TRIG: begin
                        if (mode_ok(trig_mode_t'(wv[1:0]), s.ctrl)) begin
                            n.tmode = trig_mode_t'(wv[1:0]);
                        end
                        n.dsel = wv[4:2];
                        n.tcnt = '0;
                        n.dcnt = '0;
                    end
                    OFF_THR: n.thr = wv[11:0];
                    OFF_SYNC_NOW: syn_now = wv[0];
                    OFF_DET_LO: n.det[31:0] = wv;
                    OFF_DET_HI: n.det[47:32] = wv[15:0];
                    OFF_DET_END: n.det_end = wv[8:0];
                    OFF_PLEN: n.plen = wv[9:0];
                    default: n.bresp = wr_old[32] ? RESP_SLVERR : RESP_OKAY;
                endcase
            end
        end
        // Read channel
        if (s.rvalid && rready) begin
            n.rvalid = 1'b0;
        end
        if (arvalid && s.arready) begin
            n.rvalid = 1'b1;
            n.rdata = rd_res[31:0];
            n.rresp = rd_res[32] ? RESP_SLVERR : RESP_OKAY;
        end
        // Pattern alignment and error ratio window
        unique case (s.st)
            S_HUNT: begin
                n.wbits = '0;
                n.werr = '0;
                if (!s.ctrl.pat_mem) begin
                    n.lfsr = {s.lfsr[13:0], s.rx_s};
                    n.seedc = s.seedc + 4'h1;
                    if (s.seedc == 4'(PRBS_W - 1)) begin
                        n.st = S_MEAS;
                        n.pcnt = '0;
                    end
                end else if (n.hist == s.det) begin
                    n.st = S_MEAS;
                    n.ptr = next_ptr(s.det_end, s.plen);
                end
            end
            S_MEAS, S_SYNC: begin
                n.lfsr = {s.lfsr[13:0], s.lfsr[14] ^ s.lfsr[13]};
                n.ptr = next_ptr(s.ptr, s.plen);
                n.pcnt = (s.pcnt == PRBS_LAST) ? 15'h0000 : s.pcnt + 15'h0001;
                n.wbits = s.wbits + 12'h001;
                n.werr = werr_sum;
                if (s.wbits == 12'(WIN_BITS - 1)) begin
                    n.wbits = '0;
                    n.werr = '0;
                    n.lasterr = werr_sum;
                    if (werr_sum < s.thr) begin
                        n.st = S_SYNC;
                        n.sync_ok = 1'b1;
                        n.sync_loss = 1'b0;
                    end else begin
                        n.sync_ok = 1'b0;
                        n.sync_loss = 1'b1;
                        if (!s.ctrl.manual) begin
                            n.st = S_HUNT;
                            n.seedc = '0;
                        end
                    end
                end
            end
        endcase
        if (syn_now) begin
            n.st = S_HUNT;
            n.seedc = '0;
            n.sync_ok = 1'b0;
        end
        // Trigger generation
        n.dcnt = ({1'b0, s.dcnt} >= div_len - 8'h01) ? 7'h00 : s.dcnt + 7'h01;
        if (trig_ev && s.tcnt <= 12'h001) begin
            n.tcnt = (s.tmode == T_PAT) ? TRIG_PULSE_BITS : TRIG_WIN_BITS;
        end else if (s.tcnt != '0) begin
            n.tcnt = s.tcnt - 12'h001;
        end
        case (s.tmode)
            T_DIV: n.trig = {1'b0, n.dcnt} < {1'b0, div_len[7:1]};
            T_PAT: n.trig = n.tcnt != '0;
            default: n.trig = n.tcnt > {1'b0, TRIG_WIN_BITS[11:1]};
        endcase
        // Aux output: halved clock copy or sliced data
        n.aux = s.ctrl.aux_data ? s.rx_s : ~s.aux;
        n.awready = !n.aw_h && !n.bvalid;
        n.wready = !n.w_h && !n.bvalid;
        n.arready = !n.rvalid;
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.ctrl <= ctrl_t'(CTRL_RST);
            s.thr <= THR_RST;
            s.plen <= PLEN_RST;
            s.fw_len <= '1;
        end else begin
            s <= n;
        end
    end

    // Pattern memory
    always_ff @(posedge aclk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    assign trig_out = s.trig;
    assign aux_out = s.aux;
    assign clk_sel_rec = s.ctrl.clk_rec;
    assign sync_ok = s.sync_ok;
    assign sync_loss = s.sync_loss;
    assign awready = s.awready;
    assign wready = s.wready;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = s.arready;
    assign rvalid = s.rvalid;
    assign rdata = s.rdata;
    assign rresp = s.rresp;
endmodule : bert_rx

// *** sim/bert_dut_model.sv ***
// Far-side source model: free-running serial pattern x^15+x^14+1, one bit per aclk edge.
// Assumes the bench raises noisy to spoil every third bit.
`timescale 1ns/1ps
module bert_dut_model (
    input wire logic aclk,
    input wire logic noisy,
    output logic rx_data
);
    logic [14:0] gen_r = 15'h7fff;
    logic [1:0] ph_r = 2'h0;
    logic line_r = 1'b0;

    // Generator steps each bit, the line carries its oldest bit
    always @(posedge aclk) begin
        gen_r <= {gen_r[13:0], gen_r[14] ^ gen_r[13]};
        ph_r <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
        line_r <= gen_r[14] ^ (noisy && ph_r == 2'h0);  // Error every third bit
    end
    assign rx_data = line_r;
endmodule : bert_dut_model

// *** sim/bert_rx_sva.sv ***
// Checker for bert_rx: bus answers, reset quiet, trigger shape and aux output.
// Assumes the bench offers write address and data together; bound to every bert_rx.
`timescale 1ns/1ps
module bert_rx_sva
    import bert_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic rx_data,
    input wire logic trig_out,
    input wire logic aux_out,
    input wire logic sync_ok,
    input wire logic sync_loss,
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready
);
    logic [8:0] age_r;
    logic [7:0] gap_r;
    logic [7:0] hi_r;
    logic [7:0] divn;
    logic trig_q_r;
    logic aux_d_r;
    logic [1:0] tm_r;
    logic [2:0] ds_r;
    logic cfg_wr;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Shadow of control and trigger writes, cycles since the last one
    assign cfg_wr = awvalid && awready && wvalid && wready && awaddr[11:3] == 9'h000 && wstrb[0];
    always_ff @(posedge aclk) begin
        trig_q_r <= trig_out;
        gap_r <= (trig_out && !trig_q_r) ? 8'h01 : gap_r + 8'h01;
        hi_r <= trig_out ? hi_r + 8'h01 : 8'h00;
        age_r <= (!aresetn || cfg_wr) ? 9'h000 : age_r + 9'(age_r != 9'h100);
        if (!aresetn) begin
            aux_d_r <= 1'b0;
            tm_r <= 2'h0;
            ds_r <= 3'h0;
        end else if (cfg_wr && !awaddr[2]) begin
            aux_d_r <= wdata[2];
        end else if (cfg_wr) begin
            tm_r <= wdata[1:0];
            ds_r <= wdata[4:2];
        end
    end

    // Divider length from the select field
    always_comb begin
        case (ds_r)
            3'h0: divn = 8'h04;
            3'h1: divn = 8'h08;
            3'h2: divn = 8'h10;
            3'h3: divn = 8'h14;
            3'h4: divn = 8'h20;
            3'h5: divn = 8'h40;
            default: divn = 8'h80;
        endcase
    end

    sequence s_wr_taken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence s_rd_taken;
        arvalid && arready;
    endsequence

    chk_rst_quiet: assert property (disable iff (1'b0) !aresetn |=> !trig_out && !aux_out && !sync_ok)
        else $error("trigger, aux or sync flag active after reset");
    chk_wr_answer: assert property (s_wr_taken |=> !awready && !wready ##1 bvalid)
        else $error("write answer missing two cycles after acceptance");
    chk_rd_answer: assert property (s_rd_taken |=> rvalid && !arready)
        else $error("read answer missing one cycle after acceptance");
    chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped before acceptance");
    chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read response changed before acceptance");
    chk_aux_clock: assert property (age_r == 9'h100 && !aux_d_r |=> aux_out != $past(aux_out))
        else $error("aux clock did not toggle");
    chk_aux_data: assert property (age_r == 9'h100 && aux_d_r |-> aux_out == $past(rx_data, 3))
        else $error("aux data differs from received data");
    chk_div_period: assert property ($rose(trig_out) && age_r == 9'h100 && tm_r == 2'h0 |-> gap_r == divn)
        else $error("divided trigger period wrong");
    chk_pulse_len: assert property ($fell(trig_out) && age_r == 9'h100 && tm_r < 2'h2 |-> hi_r == (tm_r == 2'h1 ? 8'h28 : divn >> 1))
        else $error("trigger pulse length wrong");
endmodule : bert_rx_sva

bind bert_rx bert_rx_sva chk (
    .aclk(aclk),
    .aresetn(aresetn),
    .rx_data(rx_data),
    .trig_out(trig_out),
    .aux_out(aux_out),
    .sync_ok(sync_ok),
    .sync_loss(sync_loss),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready)
);

// *** sim/test_bert_rx.sv ***
// Self-checking bench for bert_rx: bus reads noted in a queue, checked by a watcher.
// Assumes bert_dut_model as data source and the checker bound from its own file.
`timescale 1ns/1ps
module test_bert_rx;
    import bert_pkg::*;
    typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} note_t;
    logic aclk, aresetn, rx_data, noisy, awvalid, wvalid, bready, arvalid, rready;
    logic trig_out, aux_out, clk_sel_rec, sync_ok, sync_loss, awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    note_t exp_q[$];
    note_t note;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;
    int n_tab[7] = '{4, 8, 16, 20, 32, 64, 128};

    bert_rx uut (.aclk(aclk), .aresetn(aresetn), .rx_data(rx_data), .trig_out(trig_out), .aux_out(aux_out),
        .clk_sel_rec(clk_sel_rec), .sync_ok(sync_ok), .sync_loss(sync_loss), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready));
    bert_dut_model far (.aclk(aclk), .noisy(noisy), .rx_data(rx_data));

    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run

    task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp_word

    task automatic cmp_num(input string nm, input int e, input int g);
        check_count++;
        if (g != e) begin
            num_errors++;
            $display("wrong value %s expected %0d seen %0d", nm, e, g);
        end
    endtask : cmp_num

    // Bus write, response ready held up until the answer comes
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        bready <= 1'b0;
    endtask : wr

    // Bus read, expected answer noted first
    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m = 32'hffffffff,
                      input logic [1:0] r = RESP_OKAY);
        exp_q.push_back(note_t'{d & m, m, r});
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        rready <= 1'b0;
    endtask : rd

    function automatic logic pick(input int s);
        return s == 0 ? sync_ok : (s == 1 ? sync_loss : trig_out);
    endfunction : pick

    task automatic wait_level(input int s, input logic v, input int lim);
        int n;
        n = 0;
        while (pick(s) !== v && n < lim) begin
            @(posedge aclk);
            n++;
        end
        if (n == lim) cmp_num("wait limit", 0, lim);
    endtask : wait_level

    // High time and full period of the next trigger pulse
    task automatic measure(output int hi, output int per, input int lim);
        wait_level(2, 1'b0, lim);
        wait_level(2, 1'b1, lim);
        hi = 0;
        while (trig_out === 1'b1 && hi < lim) begin
            @(posedge aclk);
            hi++;
        end
        per = hi;
        while (trig_out === 1'b0 && per < lim) begin
            @(posedge aclk);
            per++;
        end
    endtask : measure

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    // Watcher: each read answer against the oldest note
    always @(posedge aclk) begin
        if (rvalid && rready) begin
            note = exp_q.pop_front();
            cmp_word("read data", note.d, rdata & note.m);
            cmp_word("read resp", {30'h0, note.r}, {30'h0, rresp});
        end
    end

    // Hang guard
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 99000) begin
            num_errors++;
            complete_run();
        end
    end

    initial begin
        int hi;
        int per;
        logic [31:0] v;
        {aresetn, noisy, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
        {awaddr, araddr, wdata, wstrb} = {12'h000, 12'h000, 32'h0, 4'hf};
        void'($urandom(89));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset values, read-back, unmapped place
        rd(OFF_CTRL, {24'h0, CTRL_RST});
        rd(OFF_THR, {20'h0, THR_RST});
        rd(OFF_TRIG, 32'h0);
        rd(OFF_PLEN, {22'h0, PLEN_RST});
        rd(12'h0fc, 32'h0, 32'hffffffff, RESP_SLVERR);
        v = $urandom();
        wr(OFF_DET_LO, v);
        rd(OFF_DET_LO, v);
        // Seeded lock on clean data
        wait_level(0, 1'b1, 9000);
        rd(OFF_STATUS, 32'h6);
        rd(OFF_ERRS, 32'h0);
        // Every divider length, settings 0 to 6
        for (int i = 0; i < 7; i++) begin
            wr(OFF_TRIG, {27'h0, 3'(i), 2'h0});
            repeat (260) @(posedge aclk);
            measure(hi, per, 500);
            cmp_num("divided period", n_tab[i], per);
        end
        // Mode selection refused without the matching coding setup
        wr(OFF_TRIG, 32'h2);
        rd(OFF_TRIG, 32'h0);
        wr(OFF_TRIG, 32'h3);
        rd(OFF_TRIG, 32'h0);
        wr(OFF_CTRL, 32'ha0);
        wr(OFF_TRIG, 32'h3);
        rd(OFF_TRIG, 32'h3);
        for (int k = 0; k < 16; k += 4) wr(OFF_FW + 12'(k), 32'h0);
        wr(OFF_CTRL, 32'h50);
        wr(OFF_TRIG, 32'h2);
        rd(OFF_TRIG, 32'h2);
        // All-wildcard one-symbol word matches always: window paces triggers
        measure(hi, per, 5000);
        cmp_num("filler high", 1024, hi);
        cmp_num("filler period", 2048, per);
        // Manual mode with errors: loss flagged, no resync until asked
        wr(OFF_CTRL, 32'he);
        cmp_word("recovered clock select", 32'h1, {31'h0, clk_sel_rec});
        noisy <= 1'b1;
        wait_level(1, 1'b1, 9000);
        rd(OFF_STATUS, 32'ha, 32'hb);
        noisy <= 1'b0;
        wr(OFF_SYNC_NOW, 32'h1);
        repeat (4400) @(posedge aclk);
        rd(OFF_STATUS, 32'h6);
        // Automatic mode with errors: back to hunting, relock when clean
        wr(OFF_CTRL, 32'h0);
        cmp_word("recovered clock select", 32'h0, {31'h0, clk_sel_rec});
        noisy <= 1'b1;
        wait_level(1, 1'b1, 9000);
        rd(OFF_STATUS, 32'h0, 32'h3);
        noisy <= 1'b0;
        wait_level(0, 1'b1, 9000);
        rd(OFF_STATUS, 32'h6);
        // One trigger per full pattern repetition
        wr(OFF_TRIG, 32'h1);
        measure(hi, per, 70000);
        cmp_num("pattern pulse", 40, hi);
        cmp_num("pattern period", 32767, per);
        complete_run();
    end
endmodule : test_bert_rx
